// *** common/scd_defines.svh ***
// scd_defines.svh: full register addresses, field positions and reset values of the divider controller
// assumes inclusion by the design files and the test bench by bare name
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

`define SCD_ADDR_DIV1        32'h029C0118
`define SCD_ADDR_CMD         32'h029C0138
`define SCD_ADDR_STAT        32'h029C013C
`define SCD_ADDR_ALN         32'h029C0140
`define SCD_ADDR_CHG         32'h029C0144

`define SCD_DIV_EN_BIT       15
`define SCD_RATIO_MSB        4
`define SCD_RATIO_W          5
`define SCD_RATIO_DIV2       5'h01
`define SCD_RATIO_DIV5       5'h04
`define SCD_DIV_EN_RST       1'h1
`define SCD_RATIO_RST        5'h01
`define SCD_ALN_RST          1'h1
`define SCD_CMD_RST          1'h0

`endif

// *** common/scd_pkg.sv ***
// scd_pkg.sv: types shared by the divider controller files
// assumes scd_defines.svh is visible on the include path
package scd_pkg;
    typedef enum logic [1:0] {
        SCD_IDLE  = 2'b00,
        SCD_APPLY = 2'b01,
        SCD_DONE  = 2'b10
    } scd_go_state_t;
endpackage : scd_pkg

// *** src/scd_clock_divider.sv ***
// scd_clock_divider.sv: divides the reference clock by 2 or 5
// assumes the reference clock arrives as clk; output is a registered level
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_clock_divider
    import scd_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    enable,
    input  wire logic [`SCD_RATIO_W-1:0] ratio,
    input  wire logic                    restart,
    output logic                         derivedClock
);
    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic       out_reg;
    logic       out_next;

    // terminal count: five cycles per period for code 4h, two for any other code
    function automatic logic [2:0] lastCount(input logic [`SCD_RATIO_W-1:0] r);
        lastCount = (r == `SCD_RATIO_DIV5) ? 3'h4 : 3'h1;
    endfunction : lastCount

    // count through one period; high for the first half, rounded down
    always_comb
    begin
        count_next = count_reg;
        out_next   = out_reg;
        if (!enable)
        begin
            count_next = 3'h0; // disabled: no output clock
            out_next   = 1'b0;
        end
        else if (restart || count_reg >= lastCount(ratio))
        begin
            count_next = 3'h0;
            out_next   = 1'b1; // aligned period start
        end
        else
        begin
            count_next = count_reg + 3'h1;
            out_next   = ((count_reg + 3'h1) < ((lastCount(ratio) + 3'h1) >> 1));
        end
    end

    // register the divider state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= 3'h0;
            out_reg   <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            out_reg   <= out_next;
        end
    end

    assign derivedClock = out_reg;

    stays_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        !enable ##1 !enable |-> !derivedClock)
        else $error("clock runs while disabled");
endmodule : scd_clock_divider

// *** src/scd_go_control.sv ***
// scd_go_control.sv: register port, go sequencer and divider of the secondary clock controller
// assumes a synchronous single-cycle register port on the reference clock clk
//
// Overview of operation
// - divider enable bit 15 gates the derived clock output
// - ratio code 1h divides by two, 4h by five, others reserved; the divider divides by two for every code other than 4h
// - reserved bits read zero and writes to them change nothing
// - a write of one to go bit starts a go unless one is in its apply cycle; bit stays set
// - writing zero to go bit only clears it
// - go-in-progress reads one while a go is underway, through its apply and done cycles, whether or not the ratio changes
// - without alignment a flagged ratio switches right after go
// - with alignment go realigns the clock and loads the held ratio
// - writing a different ratio sets the ratio-changed flag
// - go changes the ratio only when the flag is one
// - divider runs from the reference clock and drives derived clock
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_go_control
    import scd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [31:0] regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    output logic             derivedClock
);
    logic                    divEn_reg, divEn_next;
    logic [`SCD_RATIO_W-1:0] ratio_reg, ratio_next;
    logic [`SCD_RATIO_W-1:0] active_reg, active_next;
    logic                    goBit_reg, goBit_next;
    logic                    align_reg, align_next;
    logic                    changed_reg, changed_next;
    logic [31:0]             rdata_reg, rdata_next;
    scd_go_state_t           state_reg, state_next;
    logic                    goStart;
    logic                    restart;
    logic                    busy;

    // address match helper
    function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
        hit = (a == b);
    endfunction : hit

    assign goStart = regWrite && hit(regAddr, `SCD_ADDR_CMD) && regWdata[0];
    assign busy    = (state_reg != SCD_IDLE);

    // register writes and go sequencing
    always_comb
    begin
        divEn_next   = divEn_reg;
        ratio_next   = ratio_reg;
        active_next  = active_reg;
        goBit_next   = goBit_reg;
        align_next   = align_reg;
        changed_next = changed_reg;
        state_next   = state_reg;
        restart      = 1'b0;
        if (regWrite && hit(regAddr, `SCD_ADDR_DIV1))
        begin
            divEn_next = regWdata[`SCD_DIV_EN_BIT];
            ratio_next = regWdata[`SCD_RATIO_MSB:0];
            if (regWdata[`SCD_RATIO_MSB:0] != ratio_reg)
                changed_next = 1'b1;
        end
        if (regWrite && hit(regAddr, `SCD_ADDR_CMD))
            goBit_next = regWdata[0]; // zero only clears
        if (regWrite && hit(regAddr, `SCD_ADDR_ALN))
            align_next = regWdata[0];
        case (state_reg)
            SCD_IDLE:
            begin
                if (goStart)
                    state_next = SCD_APPLY;
            end
            SCD_APPLY:
            begin
                if (changed_reg || align_reg)
                begin
                    active_next = ratio_reg;
                    restart     = align_reg;
                end
                if (changed_reg && !(regWrite && hit(regAddr, `SCD_ADDR_DIV1)
                    && regWdata[`SCD_RATIO_MSB:0] != ratio_reg))
                    changed_next = 1'b0; // new write wins over clear
                state_next = SCD_DONE;
            end
            SCD_DONE:
            begin
                state_next = goStart ? SCD_APPLY : SCD_IDLE;
            end
            default:
            begin
                state_next = SCD_IDLE;
            end
        endcase
    end

    // read mux; reserved bits return zero
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (regRead)
        begin
            case (regAddr)
                `SCD_ADDR_DIV1: rdata_next = {16'h0000, divEn_reg, 10'h000, ratio_reg};
                `SCD_ADDR_CMD:  rdata_next = {31'h00000000, goBit_reg};
                `SCD_ADDR_STAT: rdata_next = {31'h00000000, busy};
                `SCD_ADDR_ALN:  rdata_next = {31'h00000000, align_reg};
                `SCD_ADDR_CHG:  rdata_next = {31'h00000000, changed_reg};
                default:        rdata_next = 32'h00000000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            divEn_reg   <= `SCD_DIV_EN_RST;
            ratio_reg   <= `SCD_RATIO_RST;
            active_reg  <= `SCD_RATIO_RST;
            goBit_reg   <= `SCD_CMD_RST;
            align_reg   <= `SCD_ALN_RST;
            changed_reg <= 1'b0;
            state_reg   <= SCD_IDLE;
            rdata_reg   <= 32'h00000000;
        end
        else
        begin
            divEn_reg   <= divEn_next;
            ratio_reg   <= ratio_next;
            active_reg  <= active_next;
            goBit_reg   <= goBit_next;
            align_reg   <= align_next;
            changed_reg <= changed_next;
            state_reg   <= state_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign regRdata = rdata_reg;

    // divider on the reference clock
    scd_clock_divider scd_clock_divider_i (
        .clk          (clk),
        .reset_n      (reset_n),
        .enable       (divEn_reg),
        .ratio        (active_reg),
        .restart      (restart),
        .derivedClock (derivedClock)
    );

    // go sequencing: busy only through the apply and done cycles
    go_busy_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!busy && goStart) |=> busy ##1 busy)
        else $error("go not busy");
    busy_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_DONE && !goStart) |=> !busy)
        else $error("busy held after go");
    idle_stays_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!busy && !goStart) |=> !busy)
        else $error("busy without go");
    go_ends_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!busy && goStart) |-> ##[1:4] !busy)
        else $error("go never ends");
    go_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
        goStart |=> goBit_reg)
        else $error("go bit not kept");
    zero_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == `SCD_ADDR_CMD && !regWdata[0]) |=> !goBit_reg
        && !(state_reg == SCD_APPLY && $past(state_reg) == SCD_IDLE))
        else $error("zero write acted");

    // ratio-changed flag: set by a new ratio, cleared only by an apply
    flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == `SCD_ADDR_DIV1 && regWdata[4:0] != ratio_reg)
        |=> changed_reg)
        else $error("ratio change not flagged");
    flag_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (changed_reg && state_reg != SCD_APPLY) |=> changed_reg)
        else $error("flag lost outside apply");
    flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_APPLY && changed_reg && !regWrite) |=> !changed_reg)
        else $error("flag kept after apply");

    // ratio loading and realignment in the apply cycle
    no_change_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_APPLY && !changed_reg && !align_reg) |=> $stable(active_reg))
        else $error("ratio changed without flag");
    apply_new_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_APPLY && changed_reg) |=> active_reg == $past(ratio_reg))
        else $error("new ratio not applied");
    align_load_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_APPLY && align_reg) |=> active_reg == $past(ratio_reg))
        else $error("held ratio not loaded");
    align_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == SCD_APPLY && align_reg && divEn_reg) |=> derivedClock)
        else $error("clock not realigned");

    // divider register fields take the written bits
    en_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == `SCD_ADDR_DIV1) |=> divEn_reg == $past(regWdata[`SCD_DIV_EN_BIT]))
        else $error("enable write lost");
    ratio_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == `SCD_ADDR_DIV1) |=> ratio_reg == $past(regWdata[4:0]))
        else $error("ratio write lost");

    // reserved bits of the read data
    rsvd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(regRead) && $past(regAddr) == `SCD_ADDR_STAT |-> regRdata[31:1] == 31'h0)
        else $error("reserved bits nonzero");
    bit_rsvd_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(regRead) && ($past(regAddr) == `SCD_ADDR_CMD
        || $past(regAddr) == `SCD_ADDR_ALN || $past(regAddr) == `SCD_ADDR_CHG)
        |-> regRdata[31:1] == 31'h0)
        else $error("single-bit register reserved bits nonzero");
    div_rsvd_a: assert property (@(posedge clk) disable iff (!reset_n)
        $past(regRead) && $past(regAddr) == `SCD_ADDR_DIV1
        |-> regRdata[31:16] == 16'h0000 && regRdata[14:5] == 10'h000)
        else $error("divider reserved bits nonzero");
endmodule : scd_go_control

// *** verification/scd_go_control_test.sv ***
// scd_go_control_test.sv: self-checking bench for the divider go controller
// assumes scd_pkg and scd_defines.svh are compiled and on the include path
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_go_control_test;
    logic        clk;
    logic        reset_n;
    logic [31:0] regAddr;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        derivedClock;
    int          mismatches;
    int          checks_done;
    logic [31:0] seed;
    logic [31:0] divM;
    logic [31:0] alnM;
    logic [31:0] chgM;
    logic [31:0] cmdM;
    logic [4:0]  usedR;
    logic [31:0] got;
    logic [31:0] adr [6];

    scd_go_control scd_go_control_i (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .derivedClock(derivedClock));

    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(string nm, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask : check

    // register write with model update, entered and left at a falling edge
    task automatic wr(logic [31:0] a, logic [31:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        @(negedge clk);
        if (a == `SCD_ADDR_DIV1)
        begin
            if (d[4:0] != divM[4:0]) chgM = 32'h1;
            divM = d & 32'h0000801F;
        end
        if (a == `SCD_ADDR_ALN) alnM = d & 32'h1;
        if (a == `SCD_ADDR_CMD) cmdM = d & 32'h1;
    endtask : wr

    task automatic rd(logic [31:0] a);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        got = regRdata;
        @(negedge clk);
    endtask : rd

    function automatic logic [31:0] expReg(logic [31:0] a);
        case (a)
            `SCD_ADDR_DIV1: return divM;
            `SCD_ADDR_CMD:  return cmdM;
            `SCD_ADDR_ALN:  return alnM;
            `SCD_ADDR_CHG:  return chgM;
            default:        return 32'h0;
        endcase
    endfunction : expReg

    task automatic readAll();
        foreach (adr[i])
        begin
            rd(adr[i]);
            check("register", expReg(adr[i]), got);
        end
    endtask : readAll

    // go write, then poll busy until it clears
    task automatic goRun(bit chg);
        int n;
        rd(`SCD_ADDR_STAT);
        for (n = 0; n < 4 && got !== 32'h0; n++) rd(`SCD_ADDR_STAT);
        check("idle before go", 32'h0, got);
        wr(`SCD_ADDR_CMD, (rnd() & 32'hFFFFFFFE) | 32'h1);
        rd(`SCD_ADDR_STAT);
        if (chg) check("busy", 32'h1, got);
        for (n = 0; n < 4 && got !== 32'h0; n++) rd(`SCD_ADDR_STAT);
        check("idle", 32'h0, got);
        if (chgM[0] || alnM[0]) usedR = divM[4:0];
        chgM = 32'h0;
    endtask : goRun

    // measures one high and one low run of the derived clock
    task automatic measure();
        int hi;
        int lo;
        int n;
        hi = 0;
        lo = 0;
        for (n = 0; n < 12 && derivedClock !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 12 && derivedClock !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 12 && derivedClock === 1'b1; n++)
        begin
            hi++;
            @(negedge clk);
        end
        for (n = 0; n < 12 && derivedClock === 1'b0; n++)
        begin
            lo++;
            @(negedge clk);
        end
        check("high run", (usedR == 5'h04) ? 2 : 1, hi);
        check("low run", (usedR == 5'h04) ? 3 : 1, lo);
    endtask : measure

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // watchdog
    initial
    begin
        #(25 * 4000);
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        adr = '{`SCD_ADDR_DIV1, `SCD_ADDR_CMD, `SCD_ADDR_STAT, `SCD_ADDR_ALN,
                `SCD_ADDR_CHG, 32'h029C0148};
        {regAddr, regWrite, regRead, regWdata} = '0;
        {mismatches, checks_done} = '0;
        seed = 32'h32;
        divM = 32'h00008001;
        {cmdM, chgM} = '0;
        alnM = 32'h1;
        usedR = 5'h01;
        reset_n = 1'b0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        readAll();
        measure();
        $display("reset values done");
        wr(`SCD_ADDR_ALN, rnd() & 32'hFFFFFFFE);
        wr(`SCD_ADDR_DIV1, (rnd() & 32'hFFFF7FE0) | 32'h8004);
        readAll();
        measure();
        goRun(1'b1);
        measure();
        readAll();
        $display("unaligned go done");
        goRun(1'b0);
        measure();
        wr(`SCD_ADDR_DIV1, (rnd() & 32'hFFFF7FE0) | 32'h8001);
        wr(`SCD_ADDR_CMD, rnd() & 32'hFFFFFFFE);
        readAll();
        measure();
        wr(`SCD_ADDR_ALN, 32'h1); // back to the default alignment
        goRun(1'b1);
        measure();
        $display("aligned go done");
        wr(`SCD_ADDR_DIV1, rnd() & 32'hFFFF7FE0 | 32'h1);
        repeat (3) @(negedge clk);
        repeat (10)
        begin
            check("disabled clock", 32'h0, {31'h0, derivedClock});
            @(negedge clk);
        end
        wr(32'h029C0148, rnd());
        readAll();
        $display("enable and unmapped done");
        tally_and_finish();
    end
endmodule : scd_go_control_test
